// ==== src/smpt_ctrl.sv ====
// Pass-through mode control of the buck/boost pre-regulator with APB registers
//
// Summary of operation
// - In pass-through, bootstrap pulses only on low bootstrap, at reduced rate.
// - Start-up picks buck, boost or auto from input versus output setting.
// - Start-up limits coil current rise by a soft current ramp.
// - Field 11 enters pass-through only without input UV/OV and overcurrent.
// - UV, OV, overtemperature warning or overcurrent leave pass-through.
// - Each switching activation starts the minimum-active timer; return waits for it.
// - After that timer, retry pass-through if field is 11 and no UV/OV, overtemperature warning or overcurrent.
// - Overcurrent after re-entry restarts switching after the transition time.
// - Entry ramps duty up; at 100% stop switching, filler pulses only (here no bootstrap pulses until pass-through itself).
// - After transition time, power down switching circuits, enable overcurrent detect.
// - In pass-through keep filler pulses and UV/OV monitoring alive.
// - On exit hold switching off until output below setting plus 100 mV.
// - Reduce bit set: output drops to 5 V on overtemperature warning.
// - Reduce bit cleared at power-up and on external reset pulse.
// - Field 00 on for sbc_mode 0/1, 01 adds Sleep (2), 10 reserved, 11 pass-through; sbc_mode 3 always off.
// - Switching modes: quarter-cycle bootstrap, both coil ends grounded, every 32nd cycle.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`include "smpt_defines.svh"
module smpt_ctrl #(
  parameter int ACT_CYC   = `SMPT_ACT_CYC,
  parameter int TRANS_CYC = `SMPT_TRANS_CYC
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analog indications
  input  wire logic              external_reset_line,
  input  wire logic              input_uv,
  input  wire logic              input_ov,
  input  wire logic              overtemp_warning_status,
  input  wire logic              over_current,
  input  wire logic              in_above_out,
  input  wire logic              in_near_out,
  input  wire logic              out_below_set_100mv,
  input  wire logic              duty_full,
  input  wire logic              bootstrap_low,
  input  wire logic [1:0]        sbc_mode,
  // Converter controls
  output smpt_pkg::smpt_mode_t   conv_mode,
  output logic                   switching_en,
  output logic                   input_high_switch,
  output logic                   output_high_switch,
  output logic                   coil_ground,
  output logic                   bootstrap_pulse,
  output logic                   duty_ramp_up,
  output logic                   analog_pwr_en,
  output logic                   ocd_en,
  output logic [7:0]             coil_ilim,
  output logic [3:0]             vout_sel,
  // Interrupt
  output logic                   irq
);
  import smpt_pkg::*;

  typedef struct packed {
    logic [6:0]  sync;      // sync[6:0]: two stages per input
    logic [6:0]  syn2;
    logic        rst_d;
    smpt_state_t st;
    smpt_mode_t  md;
    logic [1:0]  onoff;
    logic        otred;
    logic [3:0]  vout;
    logic [31:0] act_cnt;
    logic [31:0] tr_cnt;
    logic [31:0] pwm_cnt;
    logic [5:0]  pwm_num;
    logic        bs_on;
    logic [31:0] bs_cnt;
    logic        ocd;
    logic [7:0]  ilim;
    logic [3:0]  ist;
    logic [3:0]  imsk;
    logic [31:0] rdata;
  } smpt_s_t;

  smpt_s_t s_reg;
  smpt_s_t s_next;

  logic [6:0] pins;
  logic       uv, ov, otw, oc, rst_p, bslow, dfull;
  logic       wr, rd, pt_ok, run_ok;
  logic [3:0] ev;

  // Converter may run in the present system mode
  function automatic logic smpt_run(input logic [1:0] f, input logic [1:0] m);
    smpt_run = (m != 2'h3) && ((m != 2'h2) || (f == `SMPT_ONOFF_SLEEP) ||
               (f == `SMPT_ONOFF_PT)) && (f != 2'h2);
  endfunction

  assign pins = {external_reset_line, input_uv, input_ov, overtemp_warning_status,
                 over_current, bootstrap_low, duty_full};
  assign {rst_p, uv, ov, otw, oc, bslow, dfull} = s_reg.syn2;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pt_ok = (s_reg.onoff == `SMPT_ONOFF_PT) && !uv && !ov && !otw;
  assign run_ok = smpt_run(s_reg.onoff, sbc_mode);

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    ev = 4'h0;
    s_next.sync = pins;
    s_next.syn2 = s_reg.sync;
    s_next.rst_d = rst_p;
    if (s_reg.act_cnt != 32'd0) begin
      s_next.act_cnt = s_reg.act_cnt - 32'd1;
    end
    if (s_reg.tr_cnt != 32'd0) begin
      s_next.tr_cnt = s_reg.tr_cnt - 32'd1;
    end
    s_next.pwm_cnt = (s_reg.pwm_cnt == `SMPT_PWM_DIV - 32'd1) ? 32'd0 : s_reg.pwm_cnt + 32'd1;
    s_next.bs_on = 1'b0;
    s_next.md = in_near_out ? SMPT_MD_AUTO :
                (in_above_out ? SMPT_MD_BUCK : SMPT_MD_BOOST);
    case (s_reg.st)
      SMPT_ST_OFF: begin
        s_next.ilim = 8'h00;
        if (run_ok) begin
          s_next.st = SMPT_ST_START;
        end
      end
      SMPT_ST_START: begin
        if (s_reg.ilim < 8'hff - `SMPT_SOFT_STEP) begin
          s_next.ilim = s_reg.ilim + `SMPT_SOFT_STEP;
        end else begin
          s_next.ilim = 8'hff;
          s_next.st = SMPT_ST_SWITCH;
          s_next.act_cnt = ACT_CYC;
        end
      end
      SMPT_ST_SWITCH: begin
        if (s_reg.act_cnt == 32'd0 && pt_ok && !oc) begin
          s_next.st = SMPT_ST_RAMP;
          s_next.tr_cnt = TRANS_CYC;
        end
      end
      SMPT_ST_RAMP: begin
        if (uv || ov || otw) begin
          s_next.st = SMPT_ST_EXIT;
          ev[0] = 1'b1;
        end else if (s_reg.tr_cnt == 32'd0) begin
          s_next.st = SMPT_ST_PT;
          s_next.ocd = 1'b1;
        end
      end
      SMPT_ST_PT: begin
        if (uv || ov || otw || (s_reg.ocd && oc) || s_reg.onoff != `SMPT_ONOFF_PT) begin
          s_next.st = SMPT_ST_EXIT;
          s_next.ocd = 1'b0;
          ev[0] = 1'b1;
          ev[1] = s_reg.ocd && oc;
        end
      end
      SMPT_ST_EXIT: begin
        if (out_below_set_100mv) begin
          s_next.st = SMPT_ST_SWITCH;
          s_next.act_cnt = ACT_CYC;
        end
      end
      default: s_next.st = SMPT_ST_OFF;
    endcase
    if (!run_ok && s_reg.st != SMPT_ST_OFF) begin
      s_next.st = SMPT_ST_OFF;
      s_next.ocd = 1'b0;
    end
    if (s_reg.st == SMPT_ST_SWITCH || s_reg.st == SMPT_ST_START) begin
      // Advance at period end so the quarter-cycle pulse stays in one piece
      if (s_reg.pwm_cnt == `SMPT_PWM_DIV - 32'd1) begin
        s_next.pwm_num = (s_reg.pwm_num == `SMPT_BS_EVERY) ? 6'd0 : s_reg.pwm_num + 6'd1;
      end
      s_next.bs_on = (s_reg.pwm_num == `SMPT_BS_EVERY) &&
                     (s_reg.pwm_cnt < `SMPT_PWM_DIV / 32'd4);
    end else if (s_reg.st == SMPT_ST_PT) begin
      s_next.bs_cnt = (s_reg.bs_cnt == 32'd0) ? 32'd0 : s_reg.bs_cnt - 32'd1;
      if (bslow && s_reg.bs_cnt == 32'd0) begin
        s_next.bs_on = 1'b1;
        s_next.bs_cnt = `SMPT_BS_PT_DIV;
      end
    end else begin
      s_next.pwm_num = 6'd0;
    end
    ev[2] = otw && !s_reg.ist[2];
    ev[3] = (s_reg.st != SMPT_ST_PT) && (s_next.st == SMPT_ST_PT);
    s_next.rdata = 32'h0;
    case (paddr)
      `SMPT_OFF_CTRL:     s_next.rdata = {28'h0, s_reg.otred, 1'b0, s_reg.onoff};
      `SMPT_OFF_VOUT:     s_next.rdata = {28'h0, s_reg.vout};
      `SMPT_OFF_STATUS:   s_next.rdata = {24'h0, s_reg.ocd, uv, ov, otw, 1'b0, s_reg.st};
      `SMPT_OFF_IRQ_STAT: s_next.rdata = {28'h0, s_reg.ist};
      `SMPT_OFF_IRQ_MASK: s_next.rdata = {28'h0, s_reg.imsk};
      default:            s_next.rdata = 32'h0;
    endcase
    if (!rd) begin
      s_next.rdata = s_reg.rdata;
    end
    if (wr) begin
      case (paddr)
        `SMPT_OFF_CTRL: begin
          s_next.onoff = pwdata[`SMPT_CTRL_ONOFF_LO +: 2];
          s_next.otred = pwdata[`SMPT_CTRL_OTRED];
        end
        `SMPT_OFF_VOUT:     s_next.vout = pwdata[3:0];
        `SMPT_OFF_IRQ_STAT: s_next.ist = s_reg.ist & ~pwdata[3:0];
        `SMPT_OFF_IRQ_MASK: s_next.imsk = pwdata[3:0];
        default: ;
      endcase
    end
    s_next.ist = s_next.ist | ev; // Set wins over clear
    if (rst_p && !s_reg.rst_d) begin
      s_next.otred = 1'b0;
      s_next.onoff = `SMPT_ONOFF_RST;
      s_next.vout = `SMPT_VOUT_RST;
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.vout <= `SMPT_VOUT_RST;
      s_reg.st <= SMPT_ST_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign conv_mode = s_reg.md;
  assign switching_en = (s_reg.st == SMPT_ST_START || s_reg.st == SMPT_ST_SWITCH ||
                         (s_reg.st == SMPT_ST_RAMP && !dfull)) && !s_reg.bs_on;
  assign duty_ramp_up = (s_reg.st == SMPT_ST_RAMP);
  assign input_high_switch = (s_reg.st == SMPT_ST_PT) ||
                             (s_reg.st == SMPT_ST_RAMP && dfull);
  assign output_high_switch = input_high_switch;
  assign coil_ground = s_reg.bs_on && (s_reg.st != SMPT_ST_PT);
  assign bootstrap_pulse = s_reg.bs_on;
  assign analog_pwr_en = (s_reg.st != SMPT_ST_PT) && (s_reg.st != SMPT_ST_OFF);
  assign ocd_en = s_reg.ocd;
  assign coil_ilim = s_reg.ilim;
  assign vout_sel = (s_reg.otred && otw) ? `SMPT_VOUT_5V0 : s_reg.vout;
  assign irq = |(s_reg.ist & s_reg.imsk);

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  AST_PT_NEEDS_OK: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st != SMPT_ST_RAMP) ##1 (s_reg.st == SMPT_ST_RAMP) |-> $past(pt_ok))
    else $error("Pass-through entered without permission");
  AST_EXIT_ON_FAULT: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SMPT_ST_PT && (uv || ov || otw)) |=> (s_reg.st != SMPT_ST_PT))
    else $error("Fault did not end pass-through");
  AST_MIN_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SMPT_ST_SWITCH && s_reg.act_cnt != 32'd0) |=> (s_reg.st != SMPT_ST_RAMP))
    else $error("Left switching before minimum time");
  AST_TRANS_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SMPT_ST_RAMP && s_reg.tr_cnt != 32'd0) |=> !s_reg.ocd)
    else $error("Overcurrent detect enabled early");
  AST_PT_SWITCHES: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SMPT_ST_PT) |-> (input_high_switch && !switching_en && !analog_pwr_en))
    else $error("Pass-through switch state wrong");
  AST_EXIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SMPT_ST_EXIT) |-> !switching_en)
    else $error("Switching during exit hold");
  AST_OTRED: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.otred && otw) |-> (vout_sel == `SMPT_VOUT_5V0))
    else $error("Output not reduced on warning");
  AST_RST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_p && !s_reg.rst_d) |=> !s_reg.otred)
    else $error("Reduce bit survived reset pulse");
  AST_OC_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    (s_reg.st == SMPT_ST_SWITCH) |-> !s_reg.ocd)
    else $error("Overcurrent detect on while switching");
  AST_BS_GROUND: assert property (@(posedge pclk) disable iff (!presetn)
    coil_ground |-> !switching_en)
    else $error("Bootstrap overlaps switching");
  COV_PT: cover property (@(posedge pclk) disable iff (!presetn) s_reg.st == SMPT_ST_PT);
  COV_OC_EXIT: cover property (@(posedge pclk) disable iff (!presetn) ev[1]);
  COV_BS: cover property (@(posedge pclk) disable iff (!presetn) coil_ground);
  COV_PT_BS: cover property (@(posedge pclk) disable iff (!presetn)
    s_reg.st == SMPT_ST_PT && s_reg.bs_on);
endmodule // smpt_ctrl

// ==== pkg/smpt_defines.svh ====
// Offsets, field positions, reset values and timing counts for the pass-through control
`ifndef SMPT_DEFINES_SVH
`define SMPT_DEFINES_SVH
`define SMPT_OFF_CTRL      12'h000
`define SMPT_OFF_VOUT      12'h004
`define SMPT_OFF_STATUS    12'h008
`define SMPT_OFF_IRQ_STAT  12'h00c
`define SMPT_OFF_IRQ_MASK  12'h010
`define SMPT_CTRL_ONOFF_LO 0
`define SMPT_CTRL_OTRED    3
`define SMPT_ONOFF_RST     2'h0
`define SMPT_VOUT_RST      4'h5
`define SMPT_VOUT_5V0      4'h0
`define SMPT_ONOFF_PT      2'h3
`define SMPT_ONOFF_SLEEP   2'h1
`define SMPT_CLK_HZ        10000000
`define SMPT_ACT_MIN_US    1000
`define SMPT_TRANS_US      1000
`define SMPT_ACT_CYC       ((`SMPT_ACT_MIN_US * (`SMPT_CLK_HZ / 1000000)))
`define SMPT_TRANS_CYC     ((`SMPT_TRANS_US * (`SMPT_CLK_HZ / 1000000)))
`define SMPT_PWM_DIV       32'd100
`define SMPT_BS_EVERY      6'd31
`define SMPT_BS_PT_DIV     32'd20000
`define SMPT_SOFT_STEP     8'd4
`endif

// ==== pkg/smpt_pkg.sv ====
// Types for the pass-through control block
package smpt_pkg;
  typedef enum logic [2:0] {
    SMPT_ST_OFF     = 3'b000,
    SMPT_ST_START   = 3'b001,
    SMPT_ST_SWITCH  = 3'b011,
    SMPT_ST_RAMP    = 3'b010,
    SMPT_ST_PT      = 3'b110,
    SMPT_ST_EXIT    = 3'b111
  } smpt_state_t;
  typedef enum logic [1:0] {
    SMPT_MD_BUCK = 2'h0,
    SMPT_MD_BOOST = 2'h1,
    SMPT_MD_AUTO = 2'h2
  } smpt_mode_t;
endpackage

// ==== bench/smpt_load_model.sv ====
// Battery and load model facing the pass-through control
`timescale 1ns/1ns
module smpt_load_model (
  // Clock
  input  wire logic pclk,
  // Converter controls
  input  wire logic duty_ramp_up,
  input  wire logic analog_pwr_en,
  input  wire logic ocd_en,
  // Scenario knobs
  input  wire logic heavy_load,
  input  wire logic overtemp_warning_status,
  // Indications
  output logic      over_current,
  output logic      duty_full,
  output logic      out_below_set_100mv
);
  logic [3:0] ramp_n = 4'h0;
  logic [3:0] fall_n = 4'h0;
  always @(posedge pclk) begin
    ramp_n <= duty_ramp_up ? ramp_n + {3'h0, ramp_n != 4'hf} : 4'h0;
    fall_n <= analog_pwr_en ? fall_n + {3'h0, fall_n != 4'hf} : 4'h0;
  end
  // Duty tops out a fixed eight cycles into the ramp, whatever the load
  assign duty_full = ramp_n > 4'h7;
  // Output sags only once the analog side is back up
  assign out_below_set_100mv = fall_n > 4'h9;
  // Sensor blind while switching; load shed on a warning
  assign over_current = heavy_load && ocd_en && !overtemp_warning_status;
endmodule // smpt_load_model

// ==== bench/smpt_ctrl_tb.sv ====
// Self-checking bench for the pass-through control
`timescale 1ns/1ns
`include "smpt_defines.svh"
module smpt_ctrl_tb;
  import smpt_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int ACT = 20;
  localparam int TRN = 20;
  localparam int PER = ACT + TRN;
  typedef struct packed {
    logic [1:0] fld;
    logic [1:0] md;
    logic       nr;
    logic       ab;
    logic       on;
    logic [1:0] cm;
  } smpt_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        external_reset_line = 1'b0, input_uv = 1'b0, input_ov = 1'b0;
  logic        overtemp_warning_status = 1'b0, in_above_out = 1'b1, in_near_out = 1'b0;
  logic        bootstrap_low = 1'b0, heavy_load = 1'b0, pready, pslverr, irq;
  logic [1:0]  sbc_mode = 2'h0;
  logic        switching_en, input_high_switch, output_high_switch, coil_ground;
  logic        bootstrap_pulse, duty_ramp_up, analog_pwr_en, ocd_en, bs_q = 1'b0;
  logic        over_current, duty_full, out_below_set_100mv;
  logic [7:0]  coil_ilim, ilim_q = 8'h00;
  logic [3:0]  vout_sel;
  smpt_mode_t  conv_mode;
  int          miscompares = 0, n_tests = 0, cyc_n = 0, bs_n = 0, k0;
  smpt_row_t   rows [7] = '{
    '{2'h0, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0},
    '{2'h0, 2'h2, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 2'h1},
    '{2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h1, 2'h2, 1'b1, 1'b1, 1'b1, 2'h2},
    '{2'h1, 2'h3, 1'b0, 1'b0, 1'b0, 2'h0},
    '{2'h1, 2'h0, 1'b0, 1'b1, 1'b1, 2'h0}
  };
  smpt_ctrl #(.ACT_CYC(ACT), .TRANS_CYC(TRN)) smpt_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_line(external_reset_line), .input_uv(input_uv), .input_ov(input_ov),
    .overtemp_warning_status(overtemp_warning_status), .over_current(over_current),
    .in_above_out(in_above_out), .in_near_out(in_near_out),
    .out_below_set_100mv(out_below_set_100mv), .duty_full(duty_full),
    .bootstrap_low(bootstrap_low), .sbc_mode(sbc_mode), .conv_mode(conv_mode),
    .switching_en(switching_en), .input_high_switch(input_high_switch),
    .output_high_switch(output_high_switch), .coil_ground(coil_ground),
    .bootstrap_pulse(bootstrap_pulse), .duty_ramp_up(duty_ramp_up),
    .analog_pwr_en(analog_pwr_en), .ocd_en(ocd_en), .coil_ilim(coil_ilim),
    .vout_sel(vout_sel), .irq(irq)
  );
  smpt_load_model smpt_load_model_inst (
    .pclk(pclk), .duty_ramp_up(duty_ramp_up), .analog_pwr_en(analog_pwr_en),
    .ocd_en(ocd_en), .heavy_load(heavy_load),
    .overtemp_warning_status(overtemp_warning_status), .over_current(over_current),
    .duty_full(duty_full), .out_below_set_100mv(out_below_set_100mv)
  );
  always #50 pclk = ~pclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1);
    if (pready !== 1'b1) wrap_up();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // Bounded wait; cyc_n holds the cycles spent
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    cyc_n = 0;
    do begin
      settle(1);
      cyc_n++;
    end while (s !== v && cyc_n < lim);
    if (s !== v) begin
      chk({31'h0, s}, {31'h0, v});
      wrap_up();
    end
  endtask
  // Soft start may never step the limit by more than one increment
  always @(posedge pclk) begin
    if (presetn && {1'b0, coil_ilim} > {1'b0, ilim_q} + 9'h004) chk({24'h0, coil_ilim}, 32'h0);
    ilim_q <= coil_ilim;
    bs_q <= bootstrap_pulse;
    if (bootstrap_pulse && !bs_q) bs_n <= bs_n + 1;
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`SMPT_OFF_CTRL, 32'h0);
    rd_chk(`SMPT_OFF_VOUT, 32'h5);
    rd_chk(`SMPT_OFF_IRQ_STAT, 32'h0);
    rd_chk(`SMPT_OFF_IRQ_MASK, 32'h0);
    chk({27'h0, irq, vout_sel}, 32'h5);
    foreach (rows[i]) begin
      @(posedge pclk);
      sbc_mode <= rows[i].md;
      in_near_out <= rows[i].nr;
      in_above_out <= rows[i].ab;
      wr(`SMPT_OFF_CTRL, {30'h0, rows[i].fld});
      repeat (12) @(posedge pclk);
      apb(1'b0, `SMPT_OFF_STATUS, 32'h0, q);
      chk({31'h0, q[2:0] != 3'h0}, {31'h0, rows[i].on});
      if (rows[i].on) chk({30'h0, conv_mode}, {30'h0, rows[i].cm});
    end
    wr(`SMPT_OFF_CTRL, 32'h3);
    wait_sig(duty_ramp_up, 1'b1, 200);
    wait_sig(ocd_en, 1'b1, TRN + 10);
    chk(32'(cyc_n >= TRN - 2 && cyc_n <= TRN + 3), 32'h1);
    chk({27'h0, switching_en, input_high_switch, output_high_switch, analog_pwr_en,
         duty_ramp_up}, 32'hc);
    @(posedge pclk);
    input_uv <= 1'b1;
    wait_sig(ocd_en, 1'b0, 10);
    chk({30'h0, switching_en, analog_pwr_en}, 32'h1);
    wait_sig(switching_en, 1'b1, 40);
    chk({31'h0, out_below_set_100mv}, 32'h1);
    repeat (PER) @(posedge pclk);
    chk({31'h0, duty_ramp_up}, 32'h0);
    input_uv <= 1'b0;
    wait_sig(ocd_en, 1'b1, PER + 40);
    // Persistent overcurrent: exit, hold-off, retry, exit again
    @(posedge pclk);
    heavy_load <= 1'b1;
    wait_sig(ocd_en, 1'b0, 10);
    wait_sig(ocd_en, 1'b1, PER + 80);
    chk(32'(cyc_n >= PER && cyc_n <= PER + 60), 32'h1);
    wait_sig(ocd_en, 1'b0, 10);
    @(posedge pclk);
    heavy_load <= 1'b0;
    wait_sig(ocd_en, 1'b1, PER + 80);
    rd_chk(`SMPT_OFF_IRQ_STAT, 32'hb);
    wr(`SMPT_OFF_IRQ_MASK, 32'h2);
    settle(1);
    chk({31'h0, irq}, 32'h1);
    wr(`SMPT_OFF_IRQ_MASK, 32'h4);
    wr(`SMPT_OFF_IRQ_STAT, 32'hf);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`SMPT_OFF_IRQ_STAT, 32'h0);
    // Warning with reduction on, then off
    wr(`SMPT_OFF_VOUT, 32'h9);
    wr(`SMPT_OFF_CTRL, 32'hb);
    @(posedge pclk);
    overtemp_warning_status <= 1'b1;
    wait_sig(ocd_en, 1'b0, 10);
    settle(2);
    chk({27'h0, irq, vout_sel}, 32'h10);
    @(posedge pclk);
    overtemp_warning_status <= 1'b0;
    wr(`SMPT_OFF_CTRL, 32'h3);
    overtemp_warning_status <= 1'b1;
    settle(6);
    chk({28'h0, vout_sel}, 32'h9);
    @(posedge pclk);
    overtemp_warning_status <= 1'b0;
    wr(`SMPT_OFF_CTRL, 32'hb);
    external_reset_line <= 1'b1;
    settle(3);
    @(posedge pclk);
    external_reset_line <= 1'b0;
    settle(6);
    rd_chk(`SMPT_OFF_CTRL, 32'h0);
    rd_chk(`SMPT_OFF_VOUT, 32'h5);
    wr(12'h014, 32'hffff_ffff);
    rd_chk(12'h014, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    // Bootstrap cadence while switching
    wait_sig(coil_ground, 1'b1, 3400);
    wait_sig(coil_ground, 1'b0, 40);
    chk(32'(cyc_n), 32'h19);
    wait_sig(coil_ground, 1'b1, 3400);
    chk(32'(cyc_n >= 32'hc67 && cyc_n <= 32'hc99), 32'h1);
    // Pass-through refresh only on demand, and rate-limited
    wr(`SMPT_OFF_CTRL, 32'h3);
    wait_sig(ocd_en, 1'b1, 400);
    k0 = bs_n;
    settle(100);
    chk(32'(bs_n - k0), 32'h0);
    @(posedge pclk);
    bootstrap_low <= 1'b1;
    wait_sig(bootstrap_pulse, 1'b1, 40);
    // Let the edge counter take this pulse before the baseline
    settle(1);
    k0 = bs_n;
    settle(1000);
    chk(32'(bs_n - k0), 32'h0);
    wrap_up();
  end
endmodule // smpt_ctrl_tb
